// ---- ict_pkg.sv ----
// package for the instruction cycle timing sequencer: opcode classes, modes, request bundle
// assumes a decoder outside hands one request per instruction
package ict_pkg;
  typedef enum logic [4:0] {
    ICT_SHIFT_REG, ICT_SHIFT_MEM, ICT_SHIFT_LOOP, ICT_BIT_DYN_MEM, ICT_BIT_STAT_MEM,
    ICT_BIT_DYN_REG, ICT_BIT_STAT_REG, ICT_CBRANCH, ICT_ABRANCH, ICT_SBRANCH, ICT_DBL,
    ICT_JUMP, ICT_JSUB, ICT_LEAD, ICT_PUSHA, ICT_MMOVE_IN, ICT_MMOVE_OUT, ICT_SMOVE_IN,
    ICT_SMOVE_OUT
  } ict_class_e;
  // nineteen classes need five bits; codes above them fall to the default cost
  typedef enum logic [2:0] {
    ICT_AM_IND, ICT_AM_POSTINC, ICT_AM_PREDEC, ICT_AM_DISP, ICT_AM_INDEX,
    ICT_AM_ABSW, ICT_AM_ABSL, ICT_AM_PCDISP
  } ict_mode_e;
  typedef struct packed {
    logic [4:0] opClass;   // ict_class_e code held as plain five bits
    ict_mode_e  mode;
    logic       longSize;
    logic [1:0] variant;   // bit op: 0 change/set,1 clear,2 test; loop:0 cont,1 true,2 expired
    logic       flag;      // branch taken / decrement branch condition true
    logic [5:0] count;     // shift count or register count
    logic [7:0] eaClocks;
    logic [3:0] eaReads;
    logic [3:0] eaWrites;
  } ict_req_s;
  typedef struct packed {
    logic [9:0] clocks;
    logic [5:0] reads;
    logic [5:0] writes;
  } ict_cost_s;
  localparam logic [9:0] ICT_SHIFT_BASE_W = 10'h006;
  localparam logic [9:0] ICT_SHIFT_BASE_L = 10'h008;
  localparam logic [9:0] ICT_MIN_CLOCKS   = 10'h002;
  localparam logic [9:0] ICT_RESET_CLOCKS = 10'h000;
endpackage

// ---- ict_cost_table.sv ----
// cost lookup: turns one request into clocks, reads and writes
// assumes the request fields are stable while looked up
`timescale 1ns/100ps
module ict_cost_table (
  input  ict_pkg::ict_req_s  req,
  output ict_pkg::ict_cost_s cost
);
  function automatic logic [21:0] mk(input int c, input int r, input int w);
    mk = {c[9:0], r[5:0], w[5:0]};
  endfunction
  wire logic [9:0] n2 = {3'h0, req.count, 1'b0};
  wire logic [9:0] n4 = {2'h0, req.count, 2'h0};
  wire logic [9:0] n8 = {1'h0, req.count, 3'h0};
  wire logic [5:0] nn = req.count;
  wire logic       ind = (req.mode == ict_pkg::ICT_AM_IND);
  wire logic       pre = (req.mode == ict_pkg::ICT_AM_PREDEC);
  wire logic       absl = (req.mode == ict_pkg::ICT_AM_ABSL);
  wire logic       idx = (req.mode == ict_pkg::ICT_AM_INDEX);
  // extra cost of the richer modes for lea/pea, added twice: 0,2,4 clocks
  wire logic [9:0] modeAdd = ind ? 10'h000 : (idx || absl) ? 10'h004 : 10'h002;
  // jump and jsub: indexed costs more than absolute long, unlike lea and pea
  wire logic [9:0] jmpAdd = ind ? 10'h000 : idx ? 10'h006 : absl ? 10'h004 : 10'h002;
  // long move in from address_reg indirect starts at 24 clocks, not 12
  wire logic [9:0] lngInd = ind ? 10'h00c : 10'h000;
  wire logic [5:0] absRd = absl ? 6'h01 : 6'h00;
  wire logic [5:0] extRd = (ind || pre || req.mode == ict_pkg::ICT_AM_POSTINC) ? 6'h00 : 6'h01;
  wire logic [9:0] extClk = (ind || pre || req.mode == ict_pkg::ICT_AM_POSTINC) ? 10'h000 :
    (idx ? 10'h006 : absl ? 10'h008 : 10'h004);
  logic [21:0] b;
  always_comb begin
    b = mk(4, 1, 0);
    case (req.opClass)
      5'h00: b = {(req.longSize ? ict_pkg::ICT_SHIFT_BASE_L : ict_pkg::ICT_SHIFT_BASE_W) + n2,
                  6'h01, 6'h00};
      5'h01: b = mk(8, 1, 1);
      5'h02: begin
        if (req.variant == 2'h0) b = pre ? mk(20, 1, 1) : mk(18, 1, 1);
        else if (req.variant == 2'h1) b = pre ? mk(26, 3, 1) : mk(24, 3, 1);
        else b = pre ? mk(24, 3, 1) : mk(22, 3, 1);
      end
      5'h03: b = (req.variant == 2'h0) ? mk(8, 1, 1) : (req.variant == 2'h1) ? mk(10, 1, 1)
                 : mk(4, 1, 0);
      5'h04: b = (req.variant == 2'h0) ? mk(12, 2, 1) : (req.variant == 2'h1) ? mk(14, 2, 1)
                 : mk(8, 2, 0);
      5'h05: b = (req.variant == 2'h0) ? mk(8, 1, 0) : (req.variant == 2'h1) ? mk(10, 1, 0)
                 : mk(6, 1, 0);
      5'h06: b = (req.variant == 2'h0) ? mk(12, 2, 0) : (req.variant == 2'h1) ? mk(14, 2, 0)
                 : mk(10, 2, 0);
      5'h07: b = (req.flag || req.variant[0]) ? mk(10, 2, 0) : mk(6, 1, 0);
      5'h08: b = mk(10, 2, 0);
      5'h09: b = mk(18, 2, 2);
      5'h0a: b = (req.flag || req.variant == 2'h0) ? mk(10, 2, 0) : mk(16, 3, 0);
      5'h0b: b = {10'h008 + jmpAdd, 6'h02 + absRd + (idx ? 6'h01 : 6'h00),
                  6'h00};
      5'h0c: b = {10'h010 + jmpAdd, 6'h02 + absRd, 6'h02};
      5'h0d: b = {10'h004 + modeAdd + modeAdd, (ind ? 6'h01 : 6'h02) + absRd, 6'h00};
      5'h0e: b = {10'h00c + modeAdd + modeAdd, (ind ? 6'h01 : 6'h02) + absRd, 6'h02};
      5'h0f: b = {(req.longSize ? 10'h00c + n8 + lngInd : 10'h00c + n4) + extClk,
                  6'h03 + extRd + absRd + (req.longSize ? {nn[4:0], 1'b0} : nn),
                  6'h00};
      5'h10: b = {(req.longSize ? 10'h008 + n8 : 10'h008 + n4) + extClk,
                  6'h02 + extRd + absRd, req.longSize ? {nn[4:0], 1'b0} : nn};
      5'h11: b = {(req.longSize ? 10'h016 : 10'h012) + (absl ? 10'h006 : 10'h000),
                  (req.longSize ? 6'h04 : 6'h03) + (absl ? 6'h02 : 6'h00), 6'h00};
      5'h12: b = {(req.longSize ? 10'h016 : 10'h012) + (absl ? 10'h006 : 10'h000),
                  absl ? 6'h04 : 6'h02, req.longSize ? 6'h02 : 6'h01};
      default: b = mk(4, 1, 0);
    endcase
  end
  // effective address cost only joins entries marked plus
  wire logic eaAdd = (req.opClass == 5'h01) || (req.opClass == 5'h03) || (req.opClass == 5'h04);
  // one driver for the whole packed output
  assign cost = {b[21:12] + (eaAdd ? {2'h0, req.eaClocks} : 10'h000),
                 b[11:6] + (eaAdd ? {2'h0, req.eaReads} : 6'h00),
                 b[5:0] + (eaAdd ? {2'h0, req.eaWrites} : 6'h00)};
endmodule

// ---- ict_sequencer.sv ----
// instruction cycle sequencer: counts an instruction's clocks and paces its bus cycles
// assumes one request at a time, taken only while ready is high
`timescale 1ns/100ps
module ict_sequencer (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             start,
  input  ict_pkg::ict_req_s     req,
  output logic                  ready,
  output logic                  busRead,
  output logic                  busWrite,
  output logic                  done,
  output ict_pkg::ict_cost_s    costOut
);
  typedef enum logic [1:0] {ICT_IDLE, ICT_RUN} ict_state_e;
  ict_pkg::ict_cost_s cost;
  ict_state_e         state_q;
  logic [9:0]         clk_q;
  logic [5:0]         rd_q;
  logic [5:0]         wr_q;
  logic               ready_q, busRead_q, busWrite_q, done_q;
  ict_pkg::ict_cost_s cost_q;

  ict_cost_table uTable (
    .req  (req),
    .cost (cost)
  );

  wire logic take   = start && (state_q == ICT_IDLE);
  // reads go first, then writes, one bus cycle per clock until exhausted
  wire logic doRead  = (state_q == ICT_RUN) && (rd_q != 6'h00);
  wire logic doWrite = (state_q == ICT_RUN) && (rd_q == 6'h00) && (wr_q != 6'h00);
  wire logic last    = (state_q == ICT_RUN) && (clk_q == 10'h001);
  // a cost below the bus-cycle count would clip cycles; clock totals exceed them whenever eaClocks covers eaReads plus eaWrites
  wire logic [9:0] startClk = (cost.clocks < ict_pkg::ICT_MIN_CLOCKS) ?
                              ict_pkg::ICT_MIN_CLOCKS : cost.clocks;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ICT_IDLE;
      clk_q   <= ict_pkg::ICT_RESET_CLOCKS;
      rd_q    <= 6'h00;
      wr_q    <= 6'h00;
    end else if (take) begin
      state_q <= ICT_RUN;
      clk_q   <= startClk;
      rd_q    <= cost.reads;
      wr_q    <= cost.writes;
    end else begin
      case (state_q)
        ICT_RUN: begin
          clk_q <= clk_q - 10'h001;
          if (doRead) rd_q <= rd_q - 6'h01;
          if (doWrite) wr_q <= wr_q - 6'h01;
          if (last) state_q <= ICT_IDLE;
        end
        default: state_q <= ICT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ready_q    <= 1'b0;
      busRead_q  <= 1'b0;
      busWrite_q <= 1'b0;
      done_q     <= 1'b0;
      cost_q     <= '0;
    end else begin
      ready_q    <= (state_q == ICT_IDLE && !take) || last;
      busRead_q  <= doRead;
      busWrite_q <= doWrite;
      done_q     <= last;
      if (take) cost_q <= cost;
    end
  end

  assign ready    = ready_q;
  assign busRead  = busRead_q;
  assign busWrite = busWrite_q;
  assign done     = done_q;
  assign costOut  = cost_q;

  logic [5:0] seenRd, seenWr;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seenRd <= 6'h00;
      seenWr <= 6'h00;
    end else if (take) begin
      seenRd <= 6'h00;
      seenWr <= 6'h00;
    end else begin
      seenRd <= seenRd + {5'h00, busRead_q};
      seenWr <= seenWr + {5'h00, busWrite_q};
    end
  end

  // cycles since the taking edge, held against the tabulated total at done
  logic [9:0] elapsed_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      elapsed_q <= 10'h000;
    end else if (take) begin
      elapsed_q <= 10'h000;
    end else begin
      elapsed_q <= elapsed_q + 10'h001;
    end
  end

  reads_exact_a: assert property (@(posedge clk) disable iff (rst)
    done |-> (seenRd + {5'h00, busRead_q}) == cost_q.reads) else $error("read count wrong");
  writes_exact_a: assert property (@(posedge clk) disable iff (rst)
    done |-> (seenWr + {5'h00, busWrite_q}) == cost_q.writes) else $error("write count wrong");
  clock_total_a: assert property (@(posedge clk) disable iff (rst)
    done |-> elapsed_q == cost_q.clocks) else $error("clock total wrong");
  no_overlap_a: assert property (@(posedge clk) disable iff (rst)
    !(busRead && busWrite)) else $error("read and write together");
  shift_cost_a: assert property (@(posedge clk) disable iff (rst)
    take && req.opClass == 5'h00 && !req.longSize |=> cost_q.clocks ==
    10'h006 + {3'h0, $past(req.count), 1'b0}) else $error("shift cost wrong");
  shift_long_a: assert property (@(posedge clk) disable iff (rst)
    take && req.opClass == 5'h00 && req.longSize |=> cost_q ==
    {10'h008 + {3'h0, $past(req.count), 1'b0}, 6'h01, 6'h00}) else $error("long shift cost wrong");
  mem_shift_a: assert property (@(posedge clk) disable iff (rst)
    take && req.opClass == 5'h01 |=> cost_q == {10'h008 + {2'h0, $past(req.eaClocks)},
    6'h01 + {2'h0, $past(req.eaReads)}, 6'h01 + {2'h0, $past(req.eaWrites)}})
    else $error("memory shift cost wrong");
  loop_cont_a: assert property (@(posedge clk) disable iff (rst)
    take && req.opClass == 5'h02 && req.variant == 2'h0 && req.mode == ict_pkg::ICT_AM_PREDEC
    |=> cost_q == {10'h014, 6'h01, 6'h01}) else $error("loop continue cost wrong");
  loop_true_a: assert property (@(posedge clk) disable iff (rst)
    take && req.opClass == 5'h02 && req.variant == 2'h1 && req.mode == ict_pkg::ICT_AM_POSTINC
    |=> cost_q == {10'h018, 6'h03, 6'h01}) else $error("loop end cost wrong");
  loop_expire_a: assert property (@(posedge clk) disable iff (rst)
    take && req.opClass == 5'h02 && req.variant == 2'h2 && req.mode == ict_pkg::ICT_AM_IND
    |=> cost_q == {10'h016, 6'h03, 6'h01}) else $error("loop expiry cost wrong");
  bit_test_a: assert property (@(posedge clk) disable iff (rst)
    take && req.opClass == 5'h03 && req.variant == 2'h2 |=> cost_q ==
    {10'h004 + {2'h0, $past(req.eaClocks)}, 6'h01 + {2'h0, $past(req.eaReads)},
    {2'h0, $past(req.eaWrites)}}) else $error("dynamic bit test cost wrong");
  stat_mem_a: assert property (@(posedge clk) disable iff (rst)
    take && req.opClass == 5'h04 && req.variant == 2'h0 |=> cost_q ==
    {10'h00c + {2'h0, $past(req.eaClocks)}, 6'h02 + {2'h0, $past(req.eaReads)},
    6'h01 + {2'h0, $past(req.eaWrites)}}) else $error("static bit cost wrong");
  dyn_reg_a: assert property (@(posedge clk) disable iff (rst)
    take && req.opClass == 5'h05 && req.variant == 2'h1 |=> cost_q == {10'h00a, 6'h01, 6'h00})
    else $error("register bit clear cost wrong");
  stat_reg_a: assert property (@(posedge clk) disable iff (rst)
    take && req.opClass == 5'h06 && req.variant == 2'h2 |=> cost_q == {10'h00a, 6'h02, 6'h00})
    else $error("register bit test cost wrong");
  short_branch_a: assert property (@(posedge clk) disable iff (rst)
    take && req.opClass == 5'h07 && !req.flag && !req.variant[0] |=> ##6 done)
    else $error("short branch timing wrong");
  always_branch_a: assert property (@(posedge clk) disable iff (rst)
    take && req.opClass == 5'h08 |=> cost_q == {10'h00a, 6'h02, 6'h00})
    else $error("always branch cost wrong");
  sub_branch_a: assert property (@(posedge clk) disable iff (rst)
    take && req.opClass == 5'h09 |=> cost_q == {10'h012, 6'h02, 6'h02})
    else $error("branch to sub cost wrong");
  dbl_expire_a: assert property (@(posedge clk) disable iff (rst)
    take && req.opClass == 5'h0a && !req.flag && req.variant != 2'h0 |=>
    cost_q == {10'h010, 6'h03, 6'h00}) else $error("decrement branch cost wrong");
  jump_index_a: assert property (@(posedge clk) disable iff (rst)
    take && req.opClass == 5'h0b && req.mode == ict_pkg::ICT_AM_INDEX |=>
    cost_q == {10'h00e, 6'h03, 6'h00}) else $error("jump cost wrong");
  jsub_long_a: assert property (@(posedge clk) disable iff (rst)
    take && req.opClass == 5'h0c && req.mode == ict_pkg::ICT_AM_ABSL |=>
    cost_q == {10'h014, 6'h03, 6'h02}) else $error("jump to sub cost wrong");
  lea_ind_a: assert property (@(posedge clk) disable iff (rst)
    take && req.opClass == 5'h0d && req.mode == ict_pkg::ICT_AM_IND |=>
    cost_q == {10'h004, 6'h01, 6'h00}) else $error("load address cost wrong");
  pea_disp_a: assert property (@(posedge clk) disable iff (rst)
    take && req.opClass == 5'h0e && req.mode == ict_pkg::ICT_AM_DISP |=>
    cost_q == {10'h010, 6'h02, 6'h02}) else $error("push address cost wrong");
  mmove_in_a: assert property (@(posedge clk) disable iff (rst)
    take && req.opClass == 5'h0f && req.longSize && req.mode == ict_pkg::ICT_AM_IND |=>
    cost_q.clocks == 10'h018 + {1'h0, $past(req.count), 3'h0}) else $error("move in cost wrong");
  mmove_out_a: assert property (@(posedge clk) disable iff (rst)
    take && req.opClass == 5'h10 && !req.longSize && req.mode == ict_pkg::ICT_AM_PREDEC |=>
    cost_q == {10'h008 + {2'h0, $past(req.count), 2'h0}, 6'h02, $past(req.count)})
    else $error("move out cost wrong");
  smove_in_a: assert property (@(posedge clk) disable iff (rst)
    take && req.opClass == 5'h11 && req.longSize && req.mode == ict_pkg::ICT_AM_ABSL |=>
    cost_q == {10'h01c, 6'h06, 6'h00}) else $error("space move in cost wrong");
  smove_out_a: assert property (@(posedge clk) disable iff (rst)
    take && req.opClass == 5'h12 && req.longSize && req.mode == ict_pkg::ICT_AM_IND |=>
    cost_q == {10'h016, 6'h02, 6'h02}) else $error("space move out cost wrong");

  shift_run_c: cover property (@(posedge clk) take && req.opClass == 5'h00 ##[1:200] done);
  write_run_c: cover property (@(posedge clk) busRead ##1 busWrite);
  back_back_c: cover property (@(posedge clk) done ##1 take);
  mmove_run_c: cover property (@(posedge clk) take && req.opClass == 5'h0f ##[1:300] done);
endmodule

// ---- ict_bus_model.sv ----
// bus-side partner: tallies the read and write cycles of each instruction
// assumes one-cycle bus pulses and that done closes an instruction
`timescale 1ns/100ps
module ict_bus_model (
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  busRead,
  input  wire logic  busWrite,
  input  wire logic  done,
  output logic [5:0] rdCnt,
  output logic [5:0] wrCnt,
  output logic       orderBad
);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdCnt    <= 6'h00;
      wrCnt    <= 6'h00;
      orderBad <= 1'b0;
    end else begin
      // tallies restart after done; a read behind a write means reads were not paced first
      rdCnt    <= done ? 6'h00 : rdCnt + {5'h00, busRead};
      wrCnt    <= done ? 6'h00 : wrCnt + {5'h00, busWrite};
      orderBad <= orderBad | (busRead & (wrCnt != 6'h00));
    end
  end
endmodule

// ---- instruction_cycle_timing_tb_top.sv ----
// testbench: feeds instruction requests back to back and checks clocks and bus tallies
// assumes the sequencer takes start only while ready is high
`timescale 1ns/100ps
module instruction_cycle_timing_tb_top;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               start = 1'b0;
  logic               ready, busRead, busWrite, done, orderBad;
  logic [5:0]         rdCnt, wrCnt;
  logic [9:0]         cycCnt = 10'h000;
  logic [31:0]        seed = 32'h0000b254;
  int                 miscompares = 0;
  int                 tests_run = 0;
  ict_pkg::ict_req_s  req = '0;
  ict_pkg::ict_cost_s costOut, expNow;
  ict_pkg::ict_cost_s expQ[$];
  ict_sequencer i_ict_sequencer (.clk(clk), .rst(rst), .start(start), .req(req),
    .ready(ready), .busRead(busRead), .busWrite(busWrite), .done(done), .costOut(costOut));
  ict_bus_model i_ict_bus_model (.clk(clk), .rst(rst), .busRead(busRead), .busWrite(busWrite),
    .done(done), .rdCnt(rdCnt), .wrCnt(wrCnt), .orderBad(orderBad));
  always #12.5 clk = ~clk;
  function automatic int rn(int lim);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return int'(seed % lim);
  endfunction
  task automatic chk(string what, logic [15:0] exp, logic [15:0] seen);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // start stays high after a take, so a busy sequencer must ignore it
  task automatic t(int c, int m, int l, int v, int f, int p, int k, int r, int w,
                   int kn = 0, int kr = 0, int kw = 0, int n = 0);
    ict_pkg::ict_req_s q;
    int                i;
    q = '{5'(c), ict_pkg::ict_mode_e'(m), 1'(l), 2'(v), 1'(f), 6'(n), 8'h00, 4'(rn(3)), 4'(rn(2))};
    // address phase gets room for its own bus cycles
    q.eaClocks = 8'(4 * (q.eaReads + q.eaWrites) + 2 * rn(4));
    expQ.push_back('{10'(k + kn * n + (p ? q.eaClocks : 0)),
                     6'(r + kr * n + (p ? q.eaReads : 0)),
                     6'(w + kw * n + (p ? q.eaWrites : 0))});
    req   <= q;
    start <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ready !== 1'b1 && i < 400);
  endtask
  always @(posedge clk) begin
    cycCnt <= (start === 1'b1 && ready === 1'b1) ? 10'h000 : cycCnt + 10'h001;
  end
  always @(negedge clk) begin
    if (done === 1'b1) begin
      expNow = expQ.pop_front();
      chk("clocks", {6'h00, expNow.clocks}, {6'h00, costOut.clocks});
      chk("cycles", {6'h00, expNow.clocks}, {6'h00, cycCnt});
      chk("costRW", {4'h0, expNow.reads, expNow.writes}, {4'h0, costOut.reads, costOut.writes});
      chk("busRW", {4'h0, expNow.reads, expNow.writes}, {4'h0, rdCnt, wrCnt});
      $display("test %0d ended", tests_run / 4);
    end
  end
  initial begin
    #(25.0 * 20000);
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t(0,0,0,0,0,0,6,1,0,2,0,0,rn(64));
    t(0,0,1,0,0,0,8,1,0,2,0,0,63);
    t(1,0,0,0,0,1,8,1,1);
    t(2,0,0,0,0,0,18,1,1);
    t(2,2,0,0,0,0,20,1,1);
    t(2,1,0,1,0,0,24,3,1);
    t(2,2,0,1,0,0,26,3,1);
    t(2,0,0,2,0,0,22,3,1);
    t(2,2,0,2,0,0,24,3,1);
    t(3,0,0,1,0,1,10,1,1);
    t(3,0,0,2,0,1,4,1,0);
    t(4,0,0,0,0,1,12,2,1);
    t(5,0,1,1,0,0,10,1,0);
    t(6,0,1,2,0,0,10,2,0);
    t(7,0,0,0,0,0,6,1,0);
    t(7,0,0,1,0,0,10,2,0);
    t(8,0,0,0,0,0,10,2,0);
    t(9,0,0,0,0,0,18,2,2);
    t(10,0,0,1,0,0,16,3,0);
    t(11,4,0,0,0,0,14,3,0);
    t(11,0,0,0,0,0,8,2,0);
    t(11,3,0,0,0,0,10,2,0);
    t(12,6,0,0,0,0,20,3,2);
    t(12,4,0,0,0,0,22,2,2);
    t(13,0,0,0,0,0,4,1,0);
    t(13,6,0,0,0,0,12,3,0);
    t(14,3,0,0,0,0,16,2,2);
    t(15,0,1,0,0,0,24,3,0,8,2,0,rn(31));
    t(16,2,0,0,0,0,8,2,0,4,0,1,rn(31));
    t(17,6,1,0,0,0,28,6,0);
    t(18,0,1,0,0,0,22,2,2);
    start <= 1'b0;
    for (int j = 0; j < 300 && expQ.size() > 0; j++) @(posedge clk);
    chk("pending", 16'h0000, 16'(expQ.size()));
    chk("order", 16'h0000, {15'h0000, orderBad});
    end_of_test();
  end
endmodule
